/* lfr_pkg.sv */
// Purpose: Constants and types for the low-frequency receiver status and data registers.
// Assumes: APB slave, 32-bit data, one aligned word per register.
// Notes: Offsets of all registers are local choices.
// How it works
// - Completed byte sets byte ready bit 7
// - Byte ready plus enable requests interrupt
// - Acknowledge or byte read clears byte ready
// - Bit time error sets bit 6, data kept
// - Error stays clear in carrier mode; enable gates
// - Carrier count reached sets bit 5 unless toggle
// - ID match sets bit 4 outside carrier mode, enable gates
// - Unread byte overwritten sets overrun bit 3
// - Byte stored plus end of message sets bit 2
// - Overrun stays clear in carrier mode
// - Bit 1 selects low power sniff, reset one
// - Acknowledge one clears all six flags
// - Acknowledge self clears, reads zero
// - Reset clears all six flags
// - Byte register read-only, page zero only
// - Assemble serial bits into bytes, overwrite
// - Writes to byte register ignored
// - Reset clears enables; no global mask
package lfr_pkg;
	localparam logic [11:0] LFR_STATUS_OFS = 12'h000;
	localparam logic [11:0] LFR_BYTE_OFS = 12'h004;
	localparam logic [11:0] LFR_IRQEN_OFS = 12'h008;
	localparam logic [11:0] LFR_CTRL_OFS = 12'h00C;
	localparam logic [11:0] LFR_PAGE_OFS = 12'h010;
	localparam int LFR_READY_BIT = 7;
	localparam int LFR_ERROR_BIT = 6;
	localparam int LFR_CARRIER_BIT = 5;
	localparam int LFR_IDMATCH_BIT = 4;
	localparam int LFR_OVERRUN_BIT = 3;
	localparam int LFR_EOM_BIT = 2;
	localparam int LFR_SNIFF_BIT = 1;
	localparam int LFR_ACK_BIT = 0;
	localparam int LFR_EN_READY_BIT = 7;
	localparam int LFR_EN_ERROR_BIT = 6;
	localparam int LFR_EN_CARRIER_BIT = 5;
	localparam int LFR_EN_IDMATCH_BIT = 4;
	localparam int LFR_CTRL_TOGGLE_BIT = 4;
	localparam int LFR_CTRL_COUNT_LSB = 0;
	localparam logic LFR_SNIFF_RST = 1'b1;
	localparam logic [3:0] LFR_IRQEN_RST = 4'h0;
	localparam logic [3:0] LFR_COUNT_RST = 4'h0;
	localparam logic [2:0] LFR_BITCNT_LAST = 3'h7;

	typedef struct packed {
		logic ready;
		logic error;
		logic carrier;
		logic idmatch;
		logic overrun;
		logic eom;
	} lfr_flags_s;

	// Decoder events, one-cycle pulses on pclk
	typedef struct packed {
		logic bit_valid;
		logic bit_value;
		logic bit_time_error;
		logic end_of_message;
		logic carrier_valid;
		logic id_match;
	} lfr_events_s;
endpackage

/* lfr_status_data.sv */
// Purpose: Status flags and received byte register behind an APB slave.
// Assumes: Decoder events are synchronous to pclk, one cycle each.
// Notes: Slave answers in the access cycle, no wait states.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/10ps
module lfr_status_data (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Decoder side
	input wire lfr_pkg::lfr_events_s events,
	input wire logic carrier_mode,
	// Outputs
	output logic irq,
	output logic low_power_sniff_select,
	output logic toggle_mode_select,
	output logic [3:0] validation_count_field
);
	import lfr_pkg::*;

	lfr_flags_s flags_q;
	logic [7:0] shift_q;
	logic [2:0] bitcnt_q;
	logic [7:0] receive_byte_q;
	logic [3:0] irq_en_q;
	logic sniff_q;
	logic toggle_q;
	logic [3:0] count_q;
	logic [3:0] valcnt_q;
	logic page_q;
	logic [31:0] prdata_q;
	logic irq_q;

	logic acc;
	logic wr;
	logic rd;
	logic byte_done;
	logic ack_wr;
	logic byte_rd;
	logic carrier_hit;
	logic [7:0] byte_next;

	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign byte_next = {shift_q[6:0], events.bit_value};
	assign byte_done = events.bit_valid & ~carrier_mode & (bitcnt_q == LFR_BITCNT_LAST);
	// Acknowledge is a strobe, never stored: it self clears and reset cannot touch it
	assign ack_wr = wr & ~page_q & (paddr == LFR_STATUS_OFS) & pwdata[LFR_ACK_BIT];
	assign byte_rd = rd & ~page_q & (paddr == LFR_BYTE_OFS);
	assign carrier_hit = carrier_mode & ~toggle_q & events.carrier_valid & (valcnt_q == count_q);

	function automatic logic flag_next(input logic cur, input logic set, input logic clr);
		// Set wins so no event is lost
		flag_next = set | (cur & ~clr);
	endfunction

	// Serial assembly
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_q <= 8'h00;
			bitcnt_q <= 3'h0;
		end else if (events.bit_valid & ~carrier_mode) begin
			shift_q <= byte_next;
			bitcnt_q <= bitcnt_q + 3'h1;
		end
	end

	// Completed byte overwrites; bus writes never reach it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receive_byte_q <= 8'h00;
		end else if (byte_done) begin
			receive_byte_q <= byte_next;
		end
	end

	// Carrier validation counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			valcnt_q <= 4'h0;
		end else if (!carrier_mode || toggle_q || ack_wr) begin
			valcnt_q <= 4'h0;
		end else if (events.carrier_valid && valcnt_q != count_q) begin
			valcnt_q <= valcnt_q + 4'h1;
		end
	end

	// Flags; error, overrun and eom held clear in carrier mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= '0;
		end else begin
			flags_q.ready <= flag_next(flags_q.ready, byte_done, ack_wr | byte_rd);
			flags_q.error <= ~carrier_mode &
				flag_next(flags_q.error, events.bit_time_error, ack_wr);
			flags_q.carrier <= flag_next(flags_q.carrier, carrier_hit, ack_wr);
			flags_q.idmatch <= flag_next(flags_q.idmatch, ~carrier_mode & events.id_match,
				ack_wr);
			flags_q.overrun <= ~carrier_mode &
				flag_next(flags_q.overrun, byte_done & flags_q.ready & ~byte_rd, ack_wr);
			flags_q.eom <= ~carrier_mode &
				flag_next(flags_q.eom, byte_done & events.end_of_message, ack_wr);
		end
	end

	// Control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en_q <= LFR_IRQEN_RST;
			sniff_q <= LFR_SNIFF_RST;
			toggle_q <= 1'b0;
			count_q <= LFR_COUNT_RST;
			page_q <= 1'b0;
		end else if (wr) begin
			if (!page_q && paddr == LFR_STATUS_OFS) begin
				sniff_q <= pwdata[LFR_SNIFF_BIT];
			end
			if (paddr == LFR_IRQEN_OFS) begin
				irq_en_q <= pwdata[LFR_EN_READY_BIT:LFR_EN_IDMATCH_BIT];
			end
			if (paddr == LFR_CTRL_OFS) begin
				toggle_q <= pwdata[LFR_CTRL_TOGGLE_BIT];
				count_q <= pwdata[LFR_CTRL_COUNT_LSB +: 4];
			end
			if (paddr == LFR_PAGE_OFS) begin
				page_q <= pwdata[0];
			end
		end
	end

	// Read mux; ack bit always reads zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_q <= 32'h0000_0000;
			unique case (paddr)
				LFR_STATUS_OFS: if (!page_q) begin
					prdata_q[7:0] <= {flags_q, sniff_q, 1'b0};
				end
				LFR_BYTE_OFS: if (!page_q) begin
					prdata_q[7:0] <= receive_byte_q;
				end
				LFR_IRQEN_OFS: prdata_q[7:4] <= irq_en_q;
				LFR_CTRL_OFS: prdata_q[4:0] <= {toggle_q, count_q};
				LFR_PAGE_OFS: prdata_q[0] <= page_q;
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// Interrupt request, not subject to any global mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (flags_q.ready & irq_en_q[3]) | (flags_q.error & irq_en_q[2]) |
				(flags_q.carrier & irq_en_q[1]) | (flags_q.idmatch & irq_en_q[0]);
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign irq = irq_q;
	assign low_power_sniff_select = sniff_q;
	assign toggle_mode_select = toggle_q;
	assign validation_count_field = count_q;
endmodule

/* lfr_checker.sv */
// Purpose: Port assertions for the receiver status block
// Assumes: One pclk domain, APB without wait states
// Notes: Bound to every instance of the block
`timescale 1ns/10ps
module lfr_checker (
	// Watched ports, grouped to save room
	input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq,
	input wire logic carrier_mode, low_power_sniff_select, toggle_mode_select,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire lfr_pkg::lfr_events_s events
);
	import lfr_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire rs = acc && !pwrite && paddr == LFR_STATUS_OFS;
	wire ack = acc && pwrite && paddr == LFR_STATUS_OFS && pwdata[0];
	logic [2:0] cause_q;
	// Causes of an interrupt rise over the last three cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause_q <= 3'h0;
		end else begin
			cause_q <= {cause_q[1:0], (|events) || (acc && pwrite)};
		end
	end
	property p_rdy; acc |-> pready && !pslverr; endproperty
	a_rdy: assert property (p_rdy) else $error("access not answered at once");
	property p_ak; rs |-> !prdata[0]; endproperty
	a_ak: assert property (p_ak) else $error("acknowledge bit read as one");
	property p_hi; acc && !pwrite |-> prdata[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper read bits not zero");
	property p_sn; $rose(presetn) |-> low_power_sniff_select && !toggle_mode_select; endproperty
	a_sn: assert property (p_sn) else $error("sniff or toggle wrong after reset");
	property p_rs; $rose(presetn) |-> !irq; endproperty
	a_rs: assert property (p_rs) else $error("interrupt pending after reset");
	property p_cm; rs && carrier_mode && $past(carrier_mode) && $past(carrier_mode, 2)
		|-> prdata[6] == 1'b0 && prdata[3:2] == 2'h0; endproperty
	a_cm: assert property (p_cm) else $error("data flags set in carrier mode");
	property p_ir; $rose(irq) |-> |cause_q; endproperty
	a_ir: assert property (p_ir) else $error("interrupt rose without cause");
	property p_ck; ack && events == 6'h0 && $past(events) == 6'h0 ##1 events == 6'h0 [*2]
		|-> !irq; endproperty
	a_ck: assert property (p_ck) else $error("interrupt held after acknowledge");
endmodule
bind lfr_status_data lfr_checker u_lfr_checker(
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.pready(pready),
	.pslverr(pslverr),
	.irq(irq),
	.carrier_mode(carrier_mode),
	.low_power_sniff_select(low_power_sniff_select),
	.toggle_mode_select(toggle_mode_select),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.events(events)
);

/* lfr_core_model.sv */
// Purpose: Processor core reaching the block over APB
// Assumes: Called from the bench just after a pclk edge
// Notes: Waits on pready, bench timeout bounds it
`timescale 1ns/10ps
module lfr_core_model (
	// APB master side
	input wire logic pclk, pready,
	input wire logic [31:0] prdata,
	output logic psel, penable, pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

/* tb.sv */
// Purpose: Self-checking bench for the receiver status block
// Assumes: Decoder events are driven as single pulses
// Notes: Status reads include the sniff bit, reset one
`timescale 1ns/10ps
module tb;
	import lfr_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, carrier_mode;
	logic low_power_sniff_select, toggle_mode_select;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0] validation_count_field;
	lfr_events_s events;
	int err_count, n_checks, cyc;
	lfr_status_data u_lfr_status_data(
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.events(events),
		.carrier_mode(carrier_mode),
		.irq(irq),
		.low_power_sniff_select(low_power_sniff_select),
		.toggle_mode_select(toggle_mode_select),
		.validation_count_field(validation_count_field)
	);
	lfr_core_model u_lfr_core_model(
		.pclk(pclk),
		.pready(pready),
		.prdata(prdata),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata)
	);
	initial begin
		pclk = 0;
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc > 5000) begin
			err_count++;
			report_and_stop();
		end
	end
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] g, e);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %0t got %h expected %h", $time, g, e);
		end
	endtask
	task rc(input logic [11:0] a, input logic [31:0] e);
		u_lfr_core_model.xfer(0, a, 0, q);
		chk(q, e);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		u_lfr_core_model.xfer(1, a, d, q);
	endtask
	task pulse(input logic [5:0] e);
		@(posedge pclk) events <= e;
		@(posedge pclk) events <= '0;
	endtask
	task byte_in(input logic [7:0] b, input logic eom);
		for (int i = 7; i >= 0; i--) pulse({1'b1, b[i], 1'b0, eom && i == 0, 2'b00});
	endtask
	task t_byte;
		byte_in(8'hA5, 0);
		wr(LFR_IRQEN_OFS, 32'h80);
		rc(LFR_STATUS_OFS, 32'h82);
		chk(irq, 1);
		rc(LFR_BYTE_OFS, 32'hA5);
		rc(LFR_STATUS_OFS, 32'h02);
		chk(irq, 0);
		byte_in(8'h3C, 0);
		byte_in(8'hC3, 1);
		wr(LFR_BYTE_OFS, 32'hFF);
		wr(LFR_STATUS_OFS, 32'h02);
		rc(LFR_STATUS_OFS, 32'h8E);
		rc(LFR_BYTE_OFS, 32'hC3);
		wr(LFR_STATUS_OFS, 32'h03);
		rc(LFR_STATUS_OFS, 32'h02);
		$display("byte test done");
	endtask
	task t_flags;
		pulse(6'h08);
		pulse(6'h01);
		rc(LFR_STATUS_OFS, 32'h52);
		fork
			wr(LFR_STATUS_OFS, 32'h03);
			begin
				repeat (2) @(posedge pclk);
				events <= 6'h01;
				@(posedge pclk) events <= '0;
			end
		join
		rc(LFR_STATUS_OFS, 32'h12);
		wr(LFR_STATUS_OFS, 32'h03);
		carrier_mode <= 1;
		pulse(6'h28);
		wr(LFR_CTRL_OFS, 32'h01);
		rc(LFR_STATUS_OFS, 32'h02);
		chk(validation_count_field, 32'h1);
		pulse(6'h02);
		rc(LFR_STATUS_OFS, 32'h02);
		pulse(6'h02);
		rc(LFR_STATUS_OFS, 32'h22);
		wr(LFR_CTRL_OFS, 32'h11);
		wr(LFR_STATUS_OFS, 32'h03);
		chk(toggle_mode_select, 32'h1);
		pulse(6'h02);
		pulse(6'h02);
		rc(LFR_STATUS_OFS, 32'h02);
		carrier_mode <= 0;
		$display("flag test done");
	endtask
	task t_regs;
		wr(LFR_PAGE_OFS, 32'h01);
		rc(LFR_STATUS_OFS, 32'h00);
		wr(LFR_PAGE_OFS, 32'h00);
		wr(LFR_STATUS_OFS, 32'h00);
		rc(LFR_STATUS_OFS, 32'h00);
		chk(low_power_sniff_select, 0);
		rc(12'h020, 32'h00);
		$display("register test done");
	endtask
	initial begin
		presetn = 1'b0;
		events = '0;
		carrier_mode = 1'b0;
		err_count = 0;
		n_checks = 0;
		cyc = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1;
		rc(LFR_STATUS_OFS, 32'h02);
		rc(LFR_IRQEN_OFS, 32'h00);
		wr(LFR_STATUS_OFS, 32'h03);
		t_byte();
		t_flags();
		t_regs();
		report_and_stop();
	end
endmodule
